// ==== rtl/llm_pkg.sv ====
package llm_pkg;
	// register map, byte addresses on the register port
	localparam logic [7:0] OFF_DIVIDER = 8'h40;
	localparam logic [7:0] OFF_FWD_ADDR = 8'h41;
	localparam logic [7:0] OFF_FWD_DATA = 8'h42;
	localparam logic [7:0] OFF_BWD_DATA = 8'h43;
	localparam logic [7:0] OFF_CONTROL = 8'h44;
	localparam logic [7:0] OFF_STATUS = 8'h45;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// link_control field positions
	localparam int CTL_ENABLE_BIT = 3;
	localparam int CTL_ACK_BIT = 2;
	localparam int CTL_TX_STATE_BIT = 1;
	localparam int CTL_FORCE_BIT = 0;
	// link_control_status field positions
	localparam int STS_IE_BIT = 7;
	// sample and frame timing, in sample ticks and phases
	localparam logic [3:0] VOTE_FIRST = 4'h6;
	localparam logic [3:0] VOTE_LAST = 4'h8;
	localparam logic [3:0] PHASE_TAKE = 4'h9;
	localparam logic [3:0] LAST_SAMPLE = 4'hf;
	localparam logic [4:0] FWD_DATA_BITS = 5'h10;
	localparam logic [2:0] STOP_PHASES = 3'h4;
	localparam logic [2:0] FAIL_LOW_PHASES = 3'h4;
	localparam logic [4:0] TX_PHASES = 5'h16;
	// one decided phase of the incoming line
	typedef struct packed {
		logic valid;
		logic level;
		logic edge_seen;
		logic [3:0] count;
	} llm_phase_type;
endpackage

// ==== rtl/llm_phase_sampler.sv ====
`timescale 1ns/1ps
module llm_phase_sampler
	import llm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic tick_i,
	input wire logic line_i,
	output llm_phase_type phase_o
);
	logic s1_reg, s2_reg, s3_reg, stable_reg;
	logic s3_next, stable_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [2:0] votes_reg, votes_next;
	llm_phase_type phase_reg, phase_next;
	logic change;

	function automatic logic majority(input logic [2:0] v);
		return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// a level change counts only once the last two stages agree
	always_comb begin
		s3_next = s2_reg;
		change = (s2_reg == s3_reg) && (s3_reg != stable_reg);
		stable_next = change ? s3_reg : stable_reg;
		cnt_next = cnt_reg;
		votes_next = votes_reg;
		phase_next = phase_reg;
		phase_next.valid = 1'b0;
		phase_next.edge_seen = 1'b0;
		if (change) begin
			// [RULE_15] capture sample count
			phase_next.edge_seen = 1'b1;
			phase_next.count = cnt_reg;
			// [RULE_17] resync on edge
			cnt_next = 4'h0;
		end else if (tick_i) begin
			cnt_next = cnt_reg + 4'h1;
			// [RULE_17] vote samples six to eight
			if (cnt_next >= VOTE_FIRST && cnt_next <= VOTE_LAST) begin
				votes_next = {votes_reg[1:0], stable_reg};
			end
			if (cnt_next == PHASE_TAKE) begin
				phase_next.valid = 1'b1;
				phase_next.level = majority(votes_reg);
			end
		end
	end

	// idle line is high, so the synchroniser resets to one
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			stable_reg <= 1'b1;
			cnt_reg <= 4'h0;
			votes_reg <= 3'h7;
			phase_reg <= '0;
		end else if (ce_i) begin
			s1_reg <= line_i;
			s2_reg <= s1_reg;
			s3_reg <= s3_next;
			stable_reg <= stable_next;
			cnt_reg <= cnt_next;
			votes_reg <= votes_next;
			phase_reg <= phase_next;
		end
	end

	assign phase_o = phase_reg;
endmodule

// ==== rtl/llm_biphase_tx.sv ====
`timescale 1ns/1ps
module llm_biphase_tx
	import llm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic tick_i,
	input wire logic abort_i,
	input wire logic start_i,
	input wire logic [7:0] byte_i,
	output logic line_o,
	output logic done_o
);
	logic [21:0] shift_reg, shift_next, frame;
	logic [4:0] left_reg, left_next;
	logic [3:0] sub_reg, sub_next;
	logic busy_reg, busy_next, line_reg, line_next, done_reg, done_next;

	// start phases, data msb first as two phases each, stop phases high
	always_comb begin
		frame = {2'b01, 16'h0000, 4'hf};
		for (int i = 0; i < 8; i++) begin
			frame[4 + 2 * i] = byte_i[i];
			frame[5 + 2 * i] = ~byte_i[i];
		end
	end

	// one phase lasts sixteen sample ticks
	always_comb begin
		shift_next = shift_reg;
		left_next = left_reg;
		sub_next = sub_reg;
		busy_next = busy_reg;
		line_next = line_reg;
		done_next = 1'b0;
		if (abort_i) begin
			busy_next = 1'b0;
			line_next = 1'b1;
		end else if (start_i) begin
			// [RULE_18] backward frame layout
			busy_next = 1'b1;
			line_next = frame[21];
			shift_next = {frame[20:0], 1'b1};
			left_next = TX_PHASES - 5'h01;
			sub_next = 4'h0;
		end else if (busy_reg && tick_i) begin
			sub_next = sub_reg + 4'h1;
			if (sub_reg == LAST_SAMPLE) begin
				if (left_reg == 5'h00) begin
					busy_next = 1'b0;
					line_next = 1'b1;
					done_next = 1'b1;
				end else begin
					line_next = shift_reg[21];
					shift_next = {shift_reg[20:0], 1'b1};
					left_next = left_reg - 5'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_reg <= '1;
			left_reg <= 5'h00;
			sub_reg <= 4'h0;
			busy_reg <= 1'b0;
			line_reg <= 1'b1;
			done_reg <= 1'b0;
		end else if (ce_i) begin
			shift_reg <= shift_next;
			left_reg <= left_next;
			sub_reg <= sub_next;
			busy_reg <= busy_next;
			line_reg <= line_next;
			done_reg <= done_next;
		end
	end

	assign line_o = line_reg;
	assign done_o = done_reg;
endmodule

// ==== rtl/llm_link_controller.sv ====
//
// Contract
// [RULE_01] Sample tick is clock divided by divider plus one; sixteen ticks per phase.
// [RULE_02] Good forward frames load address and data bytes into read-only registers.
// [RULE_03] Software loads the backward byte before transmitting; reset clears it.
// [RULE_04] Upper four control bits always read zero.
// [RULE_05] Enable gates receive and transmit; changing it restarts the state machine.
// [RULE_06] Acknowledge self-clears; each next exchange waits for it.
// [RULE_07] Transmit-state bit selects transmit or receive; reset clears it.
// [RULE_08] Software sets transmit-state for replies and clears it afterwards.
// [RULE_09] Force bit transmits without a forward frame, then raises end flag.
// [RULE_10] Software should toggle enable before setting force.
// [RULE_11] Interrupt enable is the only writable status bit; reset clears it.
// [RULE_12] End flag sets at end of receive or transmit; acknowledge clears it.
// [RULE_13] Error flag sets on format or line failure; status read clears it.
// [RULE_14] Link-state flag reads one in receive, zero in transmit.
// [RULE_15] Each line edge copies the sample counter into status bits three to zero.
// [RULE_16] Status accepts writes only in bit seven.
// [RULE_17] Phase level is majority of samples six to eight; edges clear counter.
// [RULE_18] Forward frame nineteen bits, backward eleven, msb first, high stops.
// [RULE_19] In receive, line low for two bit periods sets error.
// [RULE_20] Reset and errors return the link to receive, hunting a start bit. Line-failure errors here leave the state unchanged.
// [RULE_21] Interrupt output is end flag and interrupt enable together.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module llm_link_controller
	import llm_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	input wire logic DALI_RX_I,
	output logic DALI_TX_O,
	output logic IRQ_O
);
	typedef enum logic [2:0] {
		ST_HUNT,
		ST_FIRST,
		ST_SECOND,
		ST_STOP,
		ST_WAIT_ACK,
		ST_TX
	} llm_state_type;

	function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] off);
		return strobe && (addr == off);
	endfunction

	// software registers
	logic [7:0] divider_reg, divider_next;
	logic [7:0] bwd_data_reg, bwd_data_next;
	logic enable_reg, enable_next;
	logic ack_reg, ack_next;
	logic tx_state_reg, tx_state_next;
	logic force_reg, force_next;
	logic ie_reg, ie_next;
	logic restart;

	// sample tick divider
	logic [7:0] div_cnt_reg, div_cnt_next;
	logic tick_reg, tick_next;

	// protocol state
	llm_state_type state_reg, state_next;
	logic [4:0] bit_cnt_reg, bit_cnt_next;
	logic [2:0] stop_cnt_reg, stop_cnt_next;
	logic [15:0] shift_reg, shift_next;
	logic first_reg, first_next;
	logic [7:0] fwd_addr_reg, fwd_addr_next;
	logic [7:0] fwd_data_reg, fwd_data_next;
	logic tx_start_reg, tx_start_next;
	logic [2:0] low_cnt_reg, low_cnt_next;
	logic end_set, err_set;

	// flags and outputs
	logic end_reg, end_next;
	logic err_reg, err_next;
	logic irq_reg, irq_next;
	logic [7:0] rdata_reg, rdata_next;

	llm_phase_type phase;
	logic tx_line, tx_done, abort;

	llm_phase_sampler u_sampler (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.ce_i(CE_I),
		.tick_i(tick_reg),
		.line_i(DALI_RX_I),
		.phase_o(phase)
	);

	llm_biphase_tx u_tx (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.ce_i(CE_I),
		.tick_i(tick_reg),
		.abort_i(abort),
		.start_i(tx_start_reg),
		.byte_i(bwd_data_reg),
		.line_o(tx_line),
		.done_o(tx_done)
	);

	// register writes; acknowledge lives for one cycle only
	always_comb begin
		divider_next = divider_reg;
		bwd_data_next = bwd_data_reg;
		enable_next = enable_reg;
		tx_state_next = tx_state_reg;
		force_next = force_reg;
		ie_next = ie_reg;
		// [RULE_06] acknowledge self-clears
		ack_next = 1'b0;
		restart = 1'b0;
		if (hit(WR_I, ADDR_I, OFF_DIVIDER)) begin
			divider_next = WDATA_I;
		end
		// [RULE_03] backward byte held for transmit
		if (hit(WR_I, ADDR_I, OFF_BWD_DATA)) begin
			bwd_data_next = WDATA_I;
		end
		if (hit(WR_I, ADDR_I, OFF_CONTROL)) begin
			enable_next = WDATA_I[CTL_ENABLE_BIT];
			ack_next = WDATA_I[CTL_ACK_BIT];
			// [RULE_07] transmit-state select
			tx_state_next = WDATA_I[CTL_TX_STATE_BIT];
			force_next = WDATA_I[CTL_FORCE_BIT];
			// [RULE_05] enable change restarts fsm
			restart = WDATA_I[CTL_ENABLE_BIT] != enable_reg;
		end
		// [RULE_16] only bit seven writable
		if (hit(WR_I, ADDR_I, OFF_STATUS)) begin
			// [RULE_11] interrupt enable write
			ie_next = WDATA_I[STS_IE_BIT];
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			divider_reg <= RESET_BYTE;
			bwd_data_reg <= RESET_BYTE;
			enable_reg <= 1'b0;
			ack_reg <= 1'b0;
			tx_state_reg <= 1'b0;
			force_reg <= 1'b0;
			ie_reg <= 1'b0;
		end else if (CE_I) begin
			divider_reg <= divider_next;
			bwd_data_reg <= bwd_data_next;
			enable_reg <= enable_next;
			ack_reg <= ack_next;
			tx_state_reg <= tx_state_next;
			force_reg <= force_next;
			ie_reg <= ie_next;
		end
	end

	// [RULE_01] tick every divider plus one clocks
	always_comb begin
		tick_next = 1'b0;
		div_cnt_next = div_cnt_reg + 8'h01;
		// compare with >= so shrinking the divider never waits a full wrap
		if (div_cnt_reg >= divider_reg) begin
			div_cnt_next = 8'h00;
			tick_next = 1'b1;
		end
	end

	// divider runs even when disabled so edge timing stays visible
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			div_cnt_reg <= 8'h00;
			tick_reg <= 1'b0;
		end else if (CE_I) begin
			div_cnt_reg <= div_cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign abort = !enable_reg || restart;

	// receive decoding, acknowledge wait and transmit sequencing
	always_comb begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		stop_cnt_next = stop_cnt_reg;
		shift_next = shift_reg;
		first_next = first_reg;
		fwd_addr_next = fwd_addr_reg;
		fwd_data_next = fwd_data_reg;
		tx_start_next = 1'b0;
		end_set = 1'b0;
		err_set = 1'b0;
		if (abort) begin
			// [RULE_05] disabled or restarted
			state_next = ST_HUNT;
			bit_cnt_next = 5'h00;
		end else begin
			unique case (state_reg)
				ST_HUNT: begin
					// [RULE_09] forced transmit
					if (force_reg) begin
						state_next = ST_TX;
						tx_start_next = 1'b1;
					end else if (phase.valid && !phase.level) begin
						// [RULE_20] low first half of start
						first_next = 1'b0;
						bit_cnt_next = 5'h00;
						state_next = ST_SECOND;
					end
				end
				ST_FIRST: begin
					if (phase.valid) begin
						first_next = phase.level;
						state_next = ST_SECOND;
					end
				end
				ST_SECOND: begin
					if (phase.valid) begin
						if (phase.level == first_reg) begin
							// [RULE_13] code violation
							err_set = 1'b1;
							// [RULE_20] drop frame
							state_next = ST_HUNT;
						end else begin
							// [RULE_18] second phase is the bit, msb first
							if (bit_cnt_reg != 5'h00) begin
								shift_next = {shift_reg[14:0], phase.level};
							end
							if (bit_cnt_reg == FWD_DATA_BITS) begin
								stop_cnt_next = 3'h0;
								state_next = ST_STOP;
							end else begin
								bit_cnt_next = bit_cnt_reg + 5'h01;
								state_next = ST_FIRST;
							end
						end
					end
				end
				ST_STOP: begin
					if (phase.valid) begin
						if (!phase.level) begin
							// [RULE_18] stop phases must stay high
							err_set = 1'b1;
							state_next = ST_HUNT;
						end else if (stop_cnt_reg == STOP_PHASES - 3'h1) begin
							// [RULE_02] load forward bytes
							fwd_addr_next = shift_reg[15:8];
							fwd_data_next = shift_reg[7:0];
							end_set = 1'b1;
							state_next = ST_WAIT_ACK;
						end else begin
							stop_cnt_next = stop_cnt_reg + 3'h1;
						end
					end
				end
				ST_WAIT_ACK: begin
					// [RULE_06] next exchange only after acknowledge
					if (ack_reg) begin
						if (tx_state_reg || force_reg) begin
							state_next = ST_TX;
							tx_start_next = 1'b1;
						end else begin
							state_next = ST_HUNT;
						end
					end
				end
				ST_TX: begin
					// [RULE_12] end of backward frame
					if (tx_done) begin
						end_set = 1'b1;
						state_next = ST_WAIT_ACK;
					end
				end
			endcase
		end
	end

	// [RULE_19] count consecutive low phases while receiving
	always_comb begin
		low_cnt_next = low_cnt_reg;
		if (abort || state_reg == ST_TX) begin
			low_cnt_next = 3'h0;
		end else if (phase.valid) begin
			if (phase.level) begin
				low_cnt_next = 3'h0;
			end else if (low_cnt_reg != FAIL_LOW_PHASES) begin
				low_cnt_next = low_cnt_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_reg <= ST_HUNT;
			bit_cnt_reg <= 5'h00;
			stop_cnt_reg <= 3'h0;
			shift_reg <= 16'h0000;
			first_reg <= 1'b0;
			fwd_addr_reg <= RESET_BYTE;
			fwd_data_reg <= RESET_BYTE;
			tx_start_reg <= 1'b0;
			low_cnt_reg <= 3'h0;
		end else if (CE_I) begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			stop_cnt_reg <= stop_cnt_next;
			shift_reg <= shift_next;
			first_reg <= first_next;
			fwd_addr_reg <= fwd_addr_next;
			fwd_data_reg <= fwd_data_next;
			tx_start_reg <= tx_start_next;
			low_cnt_reg <= low_cnt_next;
		end
	end

	// flags: a set in the same cycle as its clear wins
	always_comb begin
		// [RULE_12] acknowledge clears end flag
		end_next = (end_reg && !ack_reg) || end_set;
		// [RULE_13] status read clears error
		err_next = (err_reg && !hit(RD_I, ADDR_I, OFF_STATUS)) || err_set;
		// [RULE_19] line failure sets error once per low stretch
		if (low_cnt_reg == FAIL_LOW_PHASES - 3'h1 && low_cnt_next == FAIL_LOW_PHASES) begin
			err_next = 1'b1;
		end
		// [RULE_21] interrupt request
		irq_next = end_reg && ie_reg;
	end

	// read data stands one cycle after the strobe, zero otherwise
	always_comb begin
		rdata_next = 8'h00;
		if (RD_I) begin
			unique case (ADDR_I)
				OFF_DIVIDER: rdata_next = divider_reg;
				OFF_FWD_ADDR: rdata_next = fwd_addr_reg;
				OFF_FWD_DATA: rdata_next = fwd_data_reg;
				OFF_BWD_DATA: rdata_next = bwd_data_reg;
				// [RULE_04] upper control bits zero
				OFF_CONTROL: rdata_next = {4'h0, enable_reg, ack_reg, tx_state_reg, force_reg};
				// [RULE_14] link state, [RULE_15] captured count
				OFF_STATUS: rdata_next = {ie_reg, end_reg, err_reg, state_reg != ST_TX, phase.count};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			end_reg <= 1'b0;
			err_reg <= 1'b0;
			irq_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else if (CE_I) begin
			end_reg <= end_next;
			err_reg <= err_next;
			irq_reg <= irq_next;
			rdata_reg <= rdata_next;
		end
	end

	assign RDATA_O = rdata_reg;
	assign IRQ_O = irq_reg;
	assign DALI_TX_O = tx_line;
endmodule

// ==== bench/llm_link_controller_asserts.sv ====
`timescale 1ns/1ps
module llm_lc_asserts
	import llm_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [7:0] RDATA_O,
	input wire logic DALI_RX_I,
	input wire logic DALI_TX_O,
	input wire logic IRQ_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	// accesses the core takes; a frozen core ignores strobes
	logic rd_ok;
	logic wr_ok;
	assign rd_ok = RD_I && CE_I;
	assign wr_ok = WR_I && CE_I;
	// control upper nibble reads zero
	a_ctrl_upper_zero: assert property (rd_ok && ADDR_I == OFF_CONTROL |=> RDATA_O[7:4] == 4'h0)
		else $error("control upper bits not zero");
	// status write keeps only the enable bit
	a_status_ie_only: assert property ((wr_ok && ADDR_I == OFF_STATUS) ##1 (rd_ok && ADDR_I == OFF_STATUS)
		|=> RDATA_O[STS_IE_BIT] == $past(WDATA_I[STS_IE_BIT], 2)) else $error("status enable bit lost");
	// request output follows flag and enable seen in the same read
	a_irq_tracks_flags: assert property (rd_ok && ADDR_I == OFF_STATUS |=> IRQ_O == (RDATA_O[7] && RDATA_O[6]))
		else $error("interrupt request mismatch");
	// a low line means transmit state
	a_line_low_tx: assert property (rd_ok && ADDR_I == OFF_STATUS && !DALI_TX_O |=> !RDATA_O[4])
		else $error("link state high while driving low");
	// acknowledge never sticks beyond its write
	a_ack_self_clear: assert property (rd_ok && ADDR_I == OFF_CONTROL && !$past(WR_I) |=> !RDATA_O[CTL_ACK_BIT])
		else $error("acknowledge did not clear");
	// clearing enable releases the line
	a_disable_release: assert property (wr_ok && ADDR_I == OFF_CONTROL && !WDATA_I[CTL_ENABLE_BIT] |-> ##2 DALI_TX_O)
		else $error("line not released when disabled");
	// forced sequence starts a frame quickly
	a_force_starts: assert property ((wr_ok && ADDR_I == OFF_CONTROL && WDATA_I[3:0] == 4'h0) ##1
		(wr_ok && ADDR_I == OFF_BWD_DATA) ##1 (wr_ok && ADDR_I == OFF_CONTROL && WDATA_I[3:0] == 4'h9)
		|-> ##[1:4] !DALI_TX_O) else $error("forced transmit did not start");
	// second status read sees the error cleared
	a_err_read_clear: assert property ((rd_ok && ADDR_I == OFF_STATUS) ##1 (rd_ok && ADDR_I == OFF_STATUS && RDATA_O[5])
		|=> !RDATA_O[5]) else $error("error flag survived read");
endmodule
bind llm_link_controller llm_lc_asserts u_asserts (.CLK_I, .RST_N_I, .CE_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
	.RDATA_O, .DALI_RX_I, .DALI_TX_O, .IRQ_O);

// ==== bench/llm_dali_master.sv ====
`timescale 1ns/1ps
module llm_dali_master (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [15:0] frame_i,
	input wire logic low_i,
	input wire logic [9:0] phase_clks_i,
	output logic line_o,
	output logic busy_o
);
	// drive one level for a number of phases
	task automatic send(input logic lvl, input int n);
		line_o <= lvl;
		repeat (n * phase_clks_i) @(posedge clk_i);
	endtask
	// line is driven high at start and after a normal frame's stop phases; a low burst leaves it low
	initial begin
		line_o = 1'b1;
		busy_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (go_i) begin
				busy_o <= 1'b1;
				if (low_i) begin
					send(1'b0, 12);
				end else begin
					send(1'b0, 1);
					send(1'b1, 1);
					for (int i = 15; i >= 0; i--) begin
						send(!frame_i[i], 1);
						send(frame_i[i], 1);
					end
					send(1'b1, 4);
				end
				busy_o <= 1'b0;
			end
		end
	end
endmodule

// ==== bench/llm_link_controller_tb.sv ====
`timescale 1ns/1ps
module llm_link_controller_tb
	import llm_pkg::*;
;
	logic clk, rst_n, ce, wr, rd, go, low, busy, rx, tx, irq;
	logic [7:0] addr, wdata, rdata, d, v;
	logic [9:0] ph;
	logic [15:0] frame;
	int seed, err_count, n_checks;
	llm_link_controller dut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .DALI_RX_I(rx), .DALI_TX_O(tx), .IRQ_O(irq));
	llm_dali_master u_master (.clk_i(clk), .go_i(go), .frame_i(frame), .low_i(low), .phase_clks_i(ph),
		.line_o(rx), .busy_o(busy));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] dv);
		addr <= a;
		wdata <= dv;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data is taken mid-cycle, once it has settled
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] dv);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		dv = rdata;
		@(posedge clk);
	endtask
	// bounded wait: 0 request, 1 line, 2 model busy
	task automatic wait_on(input int which, input logic lvl);
		int k;
		k = 0;
		while ((which == 0 ? irq : which == 1 ? tx : busy) !== lvl && k < 20000) begin
			@(posedge clk);
			k++;
		end
		if (k == 20000) begin
			err_count++;
			report_and_stop();
		end
	endtask
	function automatic logic bwd_phase(input logic [7:0] b, input int j);
		logic bit_v;
		if (j >= 18) return 1'b1;
		bit_v = (j < 2) ? 1'b1 : b[7 - (j - 2) / 2];
		return j[0] ? bit_v : !bit_v;
	endfunction
	// sample every backward phase in its middle
	task automatic chk_bwd(input logic [7:0] b);
		wait_on(1, 1'b0);
		rd_reg(OFF_STATUS, d);
		chk("link state", d & 8'h10, 8'h00);
		repeat (ph / 2 - 3) @(posedge clk);
		for (int j = 0; j < 22; j++) begin
			chk("bwd phase", {7'h0, tx}, {7'h0, bwd_phase(b, j)});
			repeat (ph) @(posedge clk);
		end
	endtask
	initial begin
		seed = 64;
		{rst_n, wr, rd, go, low} = 5'h00;
		ce = 1'b1;
		{addr, wdata, frame} = 32'h0;
		ph = 10'h010;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// reset values; link state bit masked
		for (int i = 0; i < 7; i++) begin
			rd_reg(8'h40 + 8'(i), d);
			chk("reset or unmapped", d & (i == 5 ? 8'hef : 8'hff), 8'h00);
		end
		v = 8'($random(seed));
		wr_reg(OFF_BWD_DATA, v);
		rd_reg(OFF_BWD_DATA, d);
		chk("bwd data", d, v);
		wr_reg(OFF_FWD_ADDR, v);
		rd_reg(OFF_FWD_ADDR, d);
		chk("fwd addr ro", d, 8'h00);
		wr_reg(OFF_CONTROL, 8'hf0);
		rd_reg(OFF_CONTROL, d);
		chk("control upper", d, 8'h00);
		wr_reg(OFF_STATUS, 8'hff);
		rd_reg(OFF_STATUS, d);
		chk("status write", d & 8'he0, 8'h80);
		// frozen core ignores a write
		ce <= 1'b0;
		wr_reg(OFF_DIVIDER, 8'hff);
		ce <= 1'b1;
		rd_reg(OFF_DIVIDER, d);
		chk("frozen write", d, 8'h00);
		v = 8'($random(seed)) & 8'h03;
		ph = 10'(16 * (v + 1));
		wr_reg(OFF_DIVIDER, v);
		// forward frame, then reply
		wr_reg(OFF_CONTROL, 8'h08);
		frame <= 16'($random(seed));
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		wait_on(2, 1'b0);
		wait_on(0, 1'b1);
		rd_reg(OFF_FWD_ADDR, d);
		chk("fwd addr", d, frame[15:8]);
		rd_reg(OFF_FWD_DATA, d);
		chk("fwd data", d, frame[7:0]);
		rd_reg(OFF_STATUS, d);
		chk("end of rx", d & 8'h70, 8'h50);
		v = 8'($random(seed));
		wr_reg(OFF_BWD_DATA, v);
		wr_reg(OFF_CONTROL, 8'h0e);
		chk_bwd(v);
		wait_on(0, 1'b1);
		// acknowledge the reply so the forced run must raise the end flag afresh
		wr_reg(OFF_CONTROL, 8'h0c);
		repeat (3) @(negedge clk);
		chk("ack clears end", {7'h0, irq}, 8'h00);
		@(posedge clk);
		v = 8'($random(seed)) | 8'h80;
		addr <= OFF_CONTROL;
		wdata <= 8'h00;
		wr <= 1'b1;
		@(posedge clk);
		addr <= OFF_BWD_DATA;
		wdata <= v;
		@(posedge clk);
		addr <= OFF_CONTROL;
		wdata <= 8'h09;
		@(posedge clk);
		wr <= 1'b0;
		chk_bwd(v);
		wait_on(0, 1'b1);
		rd_reg(OFF_STATUS, d);
		chk("end of forced tx", d & 8'h40, 8'h40);
		// mask, unmask, then acknowledge the request
		for (int m = 0; m < 3; m++) begin
			wr_reg(m == 2 ? OFF_CONTROL : OFF_STATUS, m == 0 ? 8'h00 : m == 1 ? 8'h80 : 8'h04);
			repeat (3) @(negedge clk);
			chk("irq", {7'h0, irq}, {7'h0, m == 1});
			@(posedge clk);
		end
		wr_reg(OFF_CONTROL, 8'h08);
		low <= 1'b1;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		wait_on(2, 1'b0);
		addr <= OFF_STATUS;
		rd <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk("error set", rdata & 8'h20, 8'h20);
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("error cleared", rdata & 8'h20, 8'h00);
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule
